// ### core/dcc_defs.vh
/*
 * constants for the dual capture/compare unit: register offsets,
 * control field layout, mode codes and reset values.
 * assumes it is included by bare name from the design files.
 */
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// register offsets on the plain register port
`define DCC_OFS_CH1_LOW 4'h0
`define DCC_OFS_CH1_HIGH 4'h1
`define DCC_OFS_CH1_CTRL 4'h2
`define DCC_OFS_CH2_LOW 4'h3
`define DCC_OFS_CH2_HIGH 4'h4
`define DCC_OFS_CH2_CTRL 4'h5
`define DCC_OFS_TSEL 4'h6
`define DCC_OFS_FLAGS 4'h7

// control register layout
`define DCC_CTRL_MODE_MSB 3
`define DCC_CTRL_MODE_LSB 0
`define DCC_CTRL_IMPL_MASK 8'h3f

// mode field codes
`define DCC_MODE_OFF 4'h0
`define DCC_MODE_CMP_TOGGLE 4'h2
`define DCC_MODE_CAP_FALL 4'h4
`define DCC_MODE_CAP_RISE 4'h5
`define DCC_MODE_CAP_RISE4 4'h6
`define DCC_MODE_CAP_RISE16 4'h7
`define DCC_MODE_CMP_SET 4'h8
`define DCC_MODE_CMP_CLR 4'h9
`define DCC_MODE_CMP_SWI 4'ha
`define DCC_MODE_CMP_TRIG 4'hb

// prescaler terminal counts (events minus one)
`define DCC_PRE4_LAST 4'h3
`define DCC_PRE16_LAST 4'hf

// reset values
`define DCC_CTRL_RESET 8'h00
`define DCC_VALUE_RESET 16'h0000
`define DCC_TSEL_RESET 2'h0
`define DCC_FLAGS_RESET 2'h0

`endif

// ### core/dcc_unit.v
/*
 * dual capture/compare unit: two 16-bit channels that capture a timer
 * count on pin edges or compare against a timer and act on a match.
 * assumes: timer counts and the converter enable come from logic on
 * sys_clk; the pin inputs are asynchronous; the register master obeys
 * single-cycle strobes and never asserts read and write together.
 */
`timescale 1ns/1ps
`include "dcc_defs.vh"

// Contract
// - each channel keeps low byte, high byte and control, all readable and writable
// - capture copies full 16-bit count of selected timer into channel value
// - capture event: falling, rising, every 4th or 16th rising edge
// - capture sets channel flag; it stays until software clears it
// - a newer capture overwrites an unread older value
// - edges are taken from the pin level even when it is an output
// - timer choice per channel comes from selection bits in timer control
// - prescaler counter clears when channel is off or not capturing
// - changing prescale directly keeps the counter; software writes zero first
// - compare mode matches value against selected timer every cycle
// - on match output goes high, low, toggles or stays per mode
// - a compare match sets the channel flag
// - writing zero to control forces compare output latch low
// - software interrupt compare only sets the flag, pin untouched
// - channel 1 trigger resets its selected timer, making a period
// - channel 2 trigger resets its timer and starts conversion if enabled
// - trigger reset of a timer never sets that timer's overflow flag
// - mode 0000 turns the channel off and clears its state
// - capture codes 0100 fall, 0101 rise, 0110 fourth, 0111 sixteenth
// - compare codes 0010 toggle, 1000 low then high, 1001 high then low
// - 1010 software interrupt compare, 1011 trigger compare; both flag
module dcc_unit (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // channel pins, bit 0 is channel 1
   input wire [1:0] chan_pin,
   output reg [1:0] chan_out,
   // timers and converter
   input wire [15:0] first_timer_count,
   input wire [15:0] third_timer_count,
   input wire adc_enabled,
   output reg first_timer_reset,
   output reg third_timer_reset,
   output reg adc_start,
   // event flags
   output reg chan1_event_flag,
   output reg chan2_event_flag
);

   // mode classification helpers
   function is_capture;
      input [3:0] m;
      begin
         is_capture = (m == `DCC_MODE_CAP_FALL) ||
            (m == `DCC_MODE_CAP_RISE) || (m == `DCC_MODE_CAP_RISE4) ||
            (m == `DCC_MODE_CAP_RISE16);
      end
   endfunction

   function is_compare;
      input [3:0] m;
      begin
         is_compare = (m == `DCC_MODE_CMP_TOGGLE) ||
            (m == `DCC_MODE_CMP_SET) || (m == `DCC_MODE_CMP_CLR) ||
            (m == `DCC_MODE_CMP_SWI) || (m == `DCC_MODE_CMP_TRIG);
      end
   endfunction

   reg [15:0] value [0:1];
   reg [7:0] ctrl [0:1];
   reg [1:0] timer_sel; // bit set: channel uses the third timer
   reg [1:0] pin_meta;
   reg [1:0] pin_sync;
   reg [1:0] pin_prev;
   reg [3:0] pre_cnt [0:1];
   reg [1:0] match_prev;
   reg [1:0] trig;

   reg [1:0] cap_event;
   reg [1:0] match_now;
   reg [1:0] match_rise;
   reg [3:0] mode [0:1];
   reg [15:0] tcount [0:1];
   reg [1:0] edge_rise;
   reg [1:0] edge_fall;
   reg [1:0] wr_ctrl;
   // loop index of the clocked channel process only; the decode process
   // keeps a private index so that no variable has two driving processes
   integer i;

   // pin level is sampled regardless of direction
   // the pins are asynchronous, so only pin_sync may feed any logic;
   // pin_prev is the third stage, kept solely for edge detection.
   // limitation: a pulse shorter than one clock period may be missed,
   // and edges closer than one clock apart merge into one
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         pin_prev <= 2'h0;
      end else begin
         pin_meta <= chan_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // per-channel decode of mode, timer, edges and capture event
   // the prescaler compare uses the counter before this edge's update,
   // so the fourth or sixteenth edge itself fires the capture
   always @* begin : chan_decode
      integer i;
      i = 0;
      for (i = 0; i < 2; i = i + 1) begin
         mode[i] = ctrl[i][`DCC_CTRL_MODE_MSB:`DCC_CTRL_MODE_LSB];
         tcount[i] = timer_sel[i] ? third_timer_count : first_timer_count;
         edge_rise[i] = pin_sync[i] & ~pin_prev[i];
         edge_fall[i] = ~pin_sync[i] & pin_prev[i];
         wr_ctrl[i] = 1'b0;
         cap_event[i] = 1'b0;
         case (mode[i])
            `DCC_MODE_CAP_FALL: begin
               cap_event[i] = edge_fall[i];
            end
            `DCC_MODE_CAP_RISE: begin
               cap_event[i] = edge_rise[i];
            end
            `DCC_MODE_CAP_RISE4: begin
               cap_event[i] = edge_rise[i] &&
                  (pre_cnt[i] >= `DCC_PRE4_LAST);
            end
            `DCC_MODE_CAP_RISE16: begin
               cap_event[i] = edge_rise[i] &&
                  (pre_cnt[i] == `DCC_PRE16_LAST);
            end
            default: begin
               cap_event[i] = 1'b0;
            end
         endcase
         match_now[i] = is_compare(mode[i]) && (value[i] == tcount[i]);
         // act once per match so a stalled timer cannot re-toggle
         match_rise[i] = match_now[i] & ~match_prev[i];
      end
      wr_ctrl[0] = reg_wr && (reg_addr == `DCC_OFS_CH1_CTRL);
      wr_ctrl[1] = reg_wr && (reg_addr == `DCC_OFS_CH2_CTRL);
   end

   // channel value, control, prescaler and compare output
   // a capture in the cycle of a byte write wins, as it comes later in
   // this process; a fresh event is worth more than a stale write.
   // the compare latch acts only on the rising of equality, so a timer
   // that stops on the match value cannot toggle the pin again
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (i = 0; i < 2; i = i + 1) begin
            value[i] <= `DCC_VALUE_RESET;
            ctrl[i] <= `DCC_CTRL_RESET;
            pre_cnt[i] <= 4'h0;
         end
         timer_sel <= `DCC_TSEL_RESET;
         match_prev <= 2'h0;
         chan_out <= 2'h0;
      end else begin
         match_prev <= match_now;
         if (reg_wr && reg_addr == `DCC_OFS_CH1_LOW) begin
            value[0][7:0] <= reg_wdata;
         end else if (reg_wr && reg_addr == `DCC_OFS_CH1_HIGH) begin
            value[0][15:8] <= reg_wdata;
         end else if (reg_wr && reg_addr == `DCC_OFS_CH2_LOW) begin
            value[1][7:0] <= reg_wdata;
         end else if (reg_wr && reg_addr == `DCC_OFS_CH2_HIGH) begin
            value[1][15:8] <= reg_wdata;
         end else if (reg_wr && reg_addr == `DCC_OFS_TSEL) begin
            timer_sel <= reg_wdata[1:0];
         end
         for (i = 0; i < 2; i = i + 1) begin
            if (wr_ctrl[i]) begin
               ctrl[i] <= reg_wdata & `DCC_CTRL_IMPL_MASK;
            end
            // newer capture overwrites; wins over a byte write
            if (cap_event[i]) begin
               value[i] <= tcount[i];
            end
            // a direct prescale change keeps the count
            if (!is_capture(mode[i])) begin
               pre_cnt[i] <= 4'h0;
            end else if (edge_rise[i]) begin
               if (cap_event[i]) begin
                  pre_cnt[i] <= 4'h0;
               end else begin
                  pre_cnt[i] <= pre_cnt[i] + 4'h1;
               end
            end
            if (wr_ctrl[i]) begin
               // set and clear modes initialise the latch
               if (reg_wdata[3:0] == `DCC_MODE_OFF) begin
                  chan_out[i] <= 1'b0;
               end else if (reg_wdata[3:0] == `DCC_MODE_CMP_SET) begin
                  chan_out[i] <= 1'b0;
               end else if (reg_wdata[3:0] == `DCC_MODE_CMP_CLR) begin
                  chan_out[i] <= 1'b1;
               end
            end else if (match_rise[i]) begin
               // software interrupt and trigger leave pin alone
               case (mode[i])
                  `DCC_MODE_CMP_TOGGLE: begin
                     chan_out[i] <= ~chan_out[i];
                  end
                  `DCC_MODE_CMP_SET: begin
                     chan_out[i] <= 1'b1;
                  end
                  `DCC_MODE_CMP_CLR: begin
                     chan_out[i] <= 1'b0;
                  end
                  default: begin
                     chan_out[i] <= chan_out[i];
                  end
               endcase
            end
         end
      end
   end

   // special event triggers, one-cycle pulses to the timers
   // written out per channel so that this process shares no loop index
   // with the clocked logic above
   always @* begin
      trig[0] = match_rise[0] && (mode[0] == `DCC_MODE_CMP_TRIG);
      trig[1] = match_rise[1] && (mode[1] == `DCC_MODE_CMP_TRIG);
   end

   // the timer clear is registered, so the timer sees it one clock after
   // the match and the period is the compare value plus two counts.
   // both channels may clear the same timer in one cycle; the pulses
   // simply merge, which is harmless for a clear.
   // a trigger never drives an overflow line: the timer keeps its
   // overflow flag to its own wrap, not to this clear

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         first_timer_reset <= 1'b0;
         third_timer_reset <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         // channel 1 trigger clears its selected timer
         // channel 2 trigger clears its timer too
         // a separate reset line, not an overflow
         first_timer_reset <= (trig[0] & ~timer_sel[0]) |
            (trig[1] & ~timer_sel[1]);
         third_timer_reset <= (trig[0] & timer_sel[0]) |
            (trig[1] & timer_sel[1]);
         // conversion start only while converter enabled
         adc_start <= trig[1] & adc_enabled;
      end
   end

   // event flags: a hardware set in the clearing cycle wins
   // losing a clear is safe, software sees the flag again; losing an
   // event would be silent, so the set takes priority.
   // the flags register is written whole: writing zero clears, and a
   // write of one sets the flag by hand for test purposes
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chan1_event_flag <= 1'b0;
         chan2_event_flag <= 1'b0;
      end else begin
         // flags stick until software writes zero
         if (cap_event[0] || match_rise[0]) begin
            chan1_event_flag <= 1'b1;
         end else if (reg_wr && reg_addr == `DCC_OFS_FLAGS) begin
            chan1_event_flag <= reg_wdata[0];
         end
         if (cap_event[1] || match_rise[1]) begin
            chan2_event_flag <= 1'b1;
         end else if (reg_wr && reg_addr == `DCC_OFS_FLAGS) begin
            chan2_event_flag <= reg_wdata[1];
         end
      end
   end

   // read data, valid the cycle after the read strobe only
   // reads have no side effects: a flag read does not clear the flag,
   // and the two value bytes are not latched as a pair, so software
   // reading a live capture should read the flag, then both bytes.
   // idle read data is zero so a shared read bus can be or-ed together
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (!reg_rd) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == `DCC_OFS_CH1_LOW) begin
         reg_rdata <= value[0][7:0];
      end else if (reg_addr == `DCC_OFS_CH1_HIGH) begin
         reg_rdata <= value[0][15:8];
      end else if (reg_addr == `DCC_OFS_CH1_CTRL) begin
         reg_rdata <= ctrl[0];
      end else if (reg_addr == `DCC_OFS_CH2_LOW) begin
         reg_rdata <= value[1][7:0];
      end else if (reg_addr == `DCC_OFS_CH2_HIGH) begin
         reg_rdata <= value[1][15:8];
      end else if (reg_addr == `DCC_OFS_CH2_CTRL) begin
         reg_rdata <= ctrl[1];
      end else if (reg_addr == `DCC_OFS_TSEL) begin
         reg_rdata <= {6'h00, timer_sel};
      end else if (reg_addr == `DCC_OFS_FLAGS) begin
         reg_rdata <= {6'h00, chan2_event_flag, chan1_event_flag};
      end else begin
         reg_rdata <= 8'h00; // unmapped reads as zero
      end
   end

endmodule // dcc_unit

// ### test/dcc_timer.sv
/* one 16-bit timer that feeds the capture/compare unit.
 * assumes run, load and clear are synchronous to sys_clk. */
`timescale 1ns/1ps
module dcc_timer (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // control from bench and unit
   input wire run,
   input wire load,
   input wire [15:0] load_val,
   input wire clear,
   // count and overflow
   output reg [15:0] count,
   output reg ovf
);
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count <= 16'h0000;
         ovf <= 1'b0;
      end else if (clear) begin
         count <= 16'h0000;
      end else if (load) begin
         count <= load_val;
      end else if (run) begin
         count <= count + 16'h0001;
         ovf <= ovf | (count == 16'hffff);
      end
   end
endmodule // dcc_timer

// ### test/dcc_unit_sva.sv
/* port checker for the capture/compare unit.
 * assumes one clock and the register offsets of the unit. */
`timescale 1ns/1ps
module dcc_unit_chk (
   // clock and reset
   input wire sys_clk,
   input wire nrst,
   // register port
   input wire [3:0] reg_addr,
   input wire reg_rd,
   input wire reg_wr,
   input wire [7:0] reg_rdata,
   // triggers and flags
   input wire adc_enabled,
   input wire first_timer_reset,
   input wire third_timer_reset,
   input wire adc_start,
   input wire chan1_event_flag,
   input wire chan2_event_flag
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire trig = first_timer_reset | third_timer_reset;
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");
   property p_unmapped;
      $past(reg_rd) && ($past(reg_addr) > 4'h7) |-> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_ctrl_top;
      $past(reg_rd) && ($past(reg_addr) == 4'h2 || $past(reg_addr) == 4'h5)
         |-> reg_rdata[7:6] == 2'h0;
   endproperty
   a_ctrl_top: assert property (p_ctrl_top)
      else $error("control top bits not zero");
   property p_flag_read;
      $past(reg_rd) && $past(reg_addr) == 4'h7 |-> reg_rdata ==
         {6'h00, $past(chan2_event_flag), $past(chan1_event_flag)};
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag read differs from flag pins");
   property p_flag_hold;
      $fell(chan1_event_flag) |-> $past(reg_wr) && $past(reg_addr) == 4'h7;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag dropped without a flag write");
   property p_trig_pulse;
      first_timer_reset |=> !first_timer_reset;
   endproperty
   a_trig_pulse: assert property (p_trig_pulse)
      else $error("timer reset longer than one cycle");
   property p_trig_flag;
      trig |-> chan1_event_flag || chan2_event_flag;
   endproperty
   a_trig_flag: assert property (p_trig_flag)
      else $error("trigger without flag");
   property p_adc_cause;
      adc_start |-> $past(adc_enabled) && trig;
   endproperty
   a_adc_cause: assert property (p_adc_cause)
      else $error("conversion start without enabled trigger");
   c_trig: cover property (first_timer_reset);
   c_adc: cover property (adc_start);
   c_cap: cover property ($rose(chan1_event_flag));
endmodule // dcc_unit_chk

bind dcc_unit dcc_unit_chk dcc_unit_chk_i (.sys_clk(sys_clk), .nrst(nrst),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
   .reg_rdata(reg_rdata), .adc_enabled(adc_enabled),
   .first_timer_reset(first_timer_reset),
   .third_timer_reset(third_timer_reset), .adc_start(adc_start),
   .chan1_event_flag(chan1_event_flag), .chan2_event_flag(chan2_event_flag));

// ### test/test_dcc_unit.sv
/* self-checking bench for the capture/compare unit.
 * assumes the timer model and the bound checker are compiled too. */
`timescale 1ns/1ps
`include "dcc_defs.vh"
module test_dcc_unit;
   reg sys_clk = 1'b0;
   reg nrst = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [1:0] chan_pin = 2'h0;
   reg adc_enabled = 1'b0;
   reg [1:0] run = 2'h0;
   reg [1:0] ld = 2'h0;
   reg [15:0] lv = 16'h0000;
   wire [7:0] reg_rdata;
   wire [1:0] chan_out;
   wire [31:0] cnt;
   wire [1:0] ovf;
   wire first_timer_reset;
   wire third_timer_reset;
   wire adc_start;
   wire chan1_event_flag;
   wire chan2_event_flag;
   wire [1:0] flg = {chan2_event_flag, chan1_event_flag};
   integer bad_count = 0;
   integer num_checks = 0;
   integer i;
   integer c;
   integer k;
   // 10 MHz system clock
   always #50 sys_clk = ~sys_clk;
   dcc_unit dcc_unit_i (.sys_clk(sys_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_pin(chan_pin),
      .chan_out(chan_out), .first_timer_count(cnt[15:0]),
      .third_timer_count(cnt[31:16]), .adc_enabled(adc_enabled),
      .first_timer_reset(first_timer_reset),
      .third_timer_reset(third_timer_reset), .adc_start(adc_start),
      .chan1_event_flag(chan1_event_flag),
      .chan2_event_flag(chan2_event_flag));
   // index 0 is the first timer, index 1 the third
   dcc_timer dcc_timer_i [1:0] (.sys_clk(sys_clk), .nrst(nrst), .run(run),
      .load(ld), .load_val(lv),
      .clear({third_timer_reset, first_timer_reset}), .count(cnt),
      .ovf(ovf));
   task test_done;
      begin
         if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input string what, input logic [15:0] seen, input logic [15:0] e);
      begin
         num_checks = num_checks + 1;
         if (seen !== e) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", what, e, seen);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge sys_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge sys_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1;
         chk("read data", reg_rdata, e);
      end
   endtask
   // pin change then time for the two-stage synchroniser
   // pins driven as inputs
   task pin(input [1:0] p);
      begin
         @(posedge sys_clk);
         chan_pin <= p;
         tick(4);
      end
   endtask
   task tload(input [1:0] w, input [15:0] v);
      begin
         @(posedge sys_clk);
         ld <= w;
         lv <= v;
         @(posedge sys_clk);
         ld <= 2'h0;
         #1;
      end
   endtask
   // bounded wait for a timer reset pulse
   task wpulse(input [1:0] w);
      begin
         for (i = 0; i < 40 && ({third_timer_reset, first_timer_reset} & w)
            == 2'h0; i = i + 1)
            tick(1);
         if (i == 40) begin
            chk("pulse wait", 16'h0000, 16'h0001);
            test_done;
         end
      end
   endtask
   task t_regs;
      begin
         rd(4'h2, 8'h00);
         rd(4'h7, 8'h00);
         wr(4'h0, 8'ha5);
         wr(4'h1, 8'h5a);
         wr(4'h2, 8'hff);
         wr(4'h3, 8'h3c);
         wr(4'h9, 8'h77);
         rd(4'h0, 8'ha5);
         rd(4'h1, 8'h5a);
         rd(4'h2, 8'h3f);
         rd(4'h3, 8'h3c);
         rd(4'h9, 8'h00);
         wr(4'h2, 8'h00);
      end
   endtask
   task t_capture;
      begin
         wr(4'h6, 8'h01);
         tload(2'h1, 16'h1111);
         tload(2'h2, 16'hbeef);
         wr(4'h2, {4'h0, `DCC_MODE_CAP_RISE});
         pin(2'h1);
         rd(4'h0, 8'hef);
         rd(4'h1, 8'hbe);
         tload(2'h2, 16'hcafe);
         pin(2'h0);
         chk("flag", chan1_event_flag, 1'b1);
         wr(4'h7, 8'h00);
         pin(2'h1);
         rd(4'h0, 8'hfe);
         rd(4'h1, 8'hca);
         wr(4'h2, {4'h0, `DCC_MODE_CAP_FALL});
         wr(4'h7, 8'h00);
         tload(2'h2, 16'h0123);
         pin(2'h0);
         wr(4'h5, {4'h0, `DCC_MODE_CAP_RISE});
         pin(2'h2);
         rd(4'h0, 8'h23);
         rd(4'h4, 8'h11);
         rd(4'h7, 8'h03);
         wr(4'h7, 8'h00);
      end
   endtask
   // stray edges, off, then exactly n counted rising edges
   task t_pre(input [3:0] mode, input integer n);
      begin
         wr(4'h2, {4'h0, mode});
         pin(2'h1);
         pin(2'h0);
         wr(4'h2, 8'h00);
         wr(4'h7, 8'h00);
         wr(4'h2, {4'h0, mode});
         for (k = 1; k <= n; k = k + 1) begin
            tload(2'h2, k[15:0]);
            pin(2'h1);
            pin(2'h0);
            chk("prescale flag", chan1_event_flag, k == n);
         end
         rd(4'h0, n[7:0]);
         wr(4'h2, 8'h00);
         wr(4'h7, 8'h00);
      end
   endtask
   task t_compare;
      reg [19:0] modes;
      reg [4:0] init;
      reg [4:0] after;
      reg [4:0] flag;
      begin
         modes = {4'h1, `DCC_MODE_CMP_SWI, `DCC_MODE_CMP_TOGGLE,
            `DCC_MODE_CMP_CLR, `DCC_MODE_CMP_SET};
         init = 5'b00010;
         after = 5'b00101;
         flag = 5'b01111;
         wr(4'h6, 8'h00);
         for (c = 0; c < 2; c = c + 1)
            for (k = 0; k < 5; k = k + 1) begin
               tload(2'h1, 16'h0000);
               wr(c * 3, 8'h34);
               wr(c * 3 + 1, 8'h12);
               wr(c * 3 + 2, 8'h00);
               wr(4'h7, 8'h00);
               chk("latch off", chan_out[c], 1'b0);
               wr(c * 3 + 2, {4'h0, modes[k*4 +: 4]});
               chk("latch init", chan_out[c], init[k]);
               tload(2'h1, 16'h1234);
               tick(3);
               chk("latch match", chan_out[c], after[k]);
               chk("match flag", flg[c], flag[k]);
            end
      end
   endtask
   task t_trigger;
      begin
         wr(4'h2, 8'h00);
         wr(4'h5, 8'h00);
         tload(2'h1, 16'h0000);
         wr(4'h0, 8'h05);
         wr(4'h1, 8'h00);
         wr(4'h2, {4'h0, `DCC_MODE_CMP_TRIG});
         run <= 2'h1;
         wpulse(2'h1);
         tick(1);
         wpulse(2'h1);
         chk("period", i + 1, 7);
         chk("ch1 adc", adc_start, 1'b0);
         chk("overflow", ovf[0], 1'b0);
         run <= 2'h0;
         wr(4'h2, 8'h00);
         wr(4'h3, 8'h03);
         wr(4'h4, 8'h00);
         wr(4'h6, 8'h02);
         adc_enabled <= 1'b1;
         tload(2'h2, 16'h0000);
         wr(4'h5, {4'h0, `DCC_MODE_CMP_TRIG});
         run <= 2'h2;
         wpulse(2'h2);
         chk("ch2 adc", adc_start, 1'b1);
         chk("other timer", first_timer_reset, 1'b0);
         adc_enabled <= 1'b0;
         tick(1);
         wpulse(2'h2);
         chk("adc off", adc_start, 1'b0);
         run <= 2'h0;
      end
   endtask
   // reset, then the scenarios in turn
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      t_regs;
      t_capture;
      t_pre(`DCC_MODE_CAP_RISE4, 4);
      t_pre(`DCC_MODE_CAP_RISE16, 16);
      t_compare;
      t_trigger;
      test_done;
   end
endmodule // test_dcc_unit
